// ---- design/vps_power_seq.sv ----
// Power sequencer top: qualification, strap capture, limits, protection latches, both rails
//
// Function
// - Flag power-on-good once supply clears undervoltage lockout, then wait for enable.
// - Power-on-good plus enable starts start-up on the core rail, and on the graphics rail unless graphics is strap-disabled.
// - Power-on-good low starts power-down and disables all but the enable-gated ADC and host diode emulation.
// - Voltage-ID bus is invalid for 300 us after the chip is enabled.
// - Protection latches clear only on power-on-good low; enable low keeps them.
// - Limit ADC uses 255 levels over 5 V, one step per amp or degree.
// - Decoded core current, graphics current and core temperature limits are stored for host.
// - Limit ADC samples only with enable high; limits never trigger protection.
// - Boot strap decodes to 1.1 V, 1 V, 0.9 V or 0 V.
// - Wait 300 us after power-on-good and enable before any ramp.
// - Zero boot strap keeps that rail's reference at 0 V.
// - Nonzero boot ramps to boot voltage, holds, waits for a host voltage command.
// - Valid code ramps to target; ready asserts only after the target is reached.
// - Ready pins are open-drain, pulled low or released; board provides pull-up.
// - Power-down ramps the reference toward 0 V at 3.125 mV/us.
// - Below 0.2 V during power-down, shutdown completes and functions stop.
// - Ready pulls low at once when power-on-good drops.
// - Graphics sense negative above supply minus 1 V before enable disables graphics.
// - Light-load strap high forces diode emulation; low follows host power state.
// - Droop strap below 3.5 V disables droop, above 4 V enables it.
// - Slow voltage command slews the target at 3.125 mV/us.
// - Max current readable at index 21h, max temperature at 22h.
`timescale 1ns/1ps
`default_nettype none
`include "vps_power_seq_cfg.svh"

module vps_power_seq #(
  parameter int REF_W = 10
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic ce,
  input wire vps_pkg::vps_pins_t pinsAsync,
  input wire vps_pkg::vps_limits_t adcSample,
  input wire logic adcDone,
  input wire logic vidStb,
  input wire logic vidRailGfx,
  input wire logic [REF_W-1:0] vidTarget,
  input wire logic hostPsDem,
  input wire logic [7:0] regRdIndex,
  input wire logic regRdGfx,
  output logic powerOnGood_ff,
  output logic svidValid_ff,
  output logic adcEnable_ff,
  output logic droopSenseSrcEn_ff,
  output vps_pkg::vps_strap_t strap_ff,
  output vps_pkg::vps_faults_t faultLatch_ff,
  output vps_pkg::vps_limits_t limits_ff,
  output logic gfxDiodeEmulationMode_ff,
  output logic [REF_W-1:0] coreRef_ff,
  output logic [REF_W-1:0] gfxRef_ff,
  output logic coreReadyOut_ff,
  output logic coreReadyOeN_ff,
  output logic gfxReadyOut_ff,
  output logic gfxReadyOeN_ff,
  output logic [1:0] readyLineLevel_ff,
  output logic [7:0] regRdData_ff,
  output logic railsActive_ff
);

  // ========================================================================
  // Timing counts derived from the clock rate
  localparam logic [11:0] QUAL_CYC = 12'(`VPS_QUAL_US * `VPS_CLK_MHZ);
  localparam logic [11:0] SERIAL_VOLTAGE_ID_BUS_CYC = 12'(`VPS_SERIAL_VOLTAGE_ID_BUS_INVALID_US * `VPS_CLK_MHZ);
  localparam logic [7:0] SLEW_CYC = 8'(`VPS_REF_STEP_UV * `VPS_CLK_MHZ / `VPS_SLEW_UV_PER_US);
  localparam logic [7:0] ADC_LEVELS = 8'(`VPS_ADC_LEVELS);

  // Boot strap level to reference steps, used for both rails
  function automatic logic [REF_W-1:0] bootSteps(input vps_pkg::vps_boot_t b);
    unique case (b)
      vps_pkg::VPS_BOOT_1V1: bootSteps = REF_W'(`VPS_BOOT_1V1_MV * `VPS_UV_PER_MV / `VPS_REF_STEP_UV);
      vps_pkg::VPS_BOOT_1V0: bootSteps = REF_W'(`VPS_BOOT_1V0_MV * `VPS_UV_PER_MV / `VPS_REF_STEP_UV);
      vps_pkg::VPS_BOOT_0V9: bootSteps = REF_W'(`VPS_BOOT_0V9_MV * `VPS_UV_PER_MV / `VPS_REF_STEP_UV);
      vps_pkg::VPS_BOOT_0V0: bootSteps = '0;
    endcase
  endfunction

  // Two-threshold decision: keep the old value in the dead band
  function automatic logic hystPick(input logic hi, input logic lo, input logic prev);
    hystPick = hi ? 1'b1 : (lo ? 1'b0 : prev);
  endfunction

  // ========================================================================
  // Pin synchronisers; stage one feeds only stage two
  vps_pkg::vps_pins_t sync1_ff;
  vps_pkg::vps_pins_t sync2_ff;

  always_ff @(posedge clock) begin
    if (srst) begin
      sync1_ff <= '0;
      sync2_ff <= '0;
    end else if (ce) begin
      sync1_ff <= pinsAsync;
      sync2_ff <= sync1_ff;
    end
  end

  // ========================================================================
  // Qualified levels
  wire porS = sync2_ff.supplyAboveUvlo;
  wire enS = sync2_ff.enableAboveThreshold;
  wire chipOn = porS & enS;

  logic [11:0] qualCnt_ff;
  logic [11:0] nxt_qualCnt;
  logic [7:0] slewCnt_ff;
  logic [7:0] nxt_slewCnt;

  // Qualification timer restarts whenever power-on-good or enable drops; next value sits beside the rails
  wire qualDone = chipOn && (qualCnt_ff == QUAL_CYC - 12'h001);
  // Bus validity shares the timer, so its delay must not exceed qualification
  wire svidOpen = chipOn && (qualCnt_ff >= SERIAL_VOLTAGE_ID_BUS_CYC);
  // Free-running slew divider: one reference step per tick
  assign nxt_slewCnt = (slewCnt_ff == SLEW_CYC - 8'h01) ? 8'h00 : slewCnt_ff + 8'h01;
  wire slewTick = (slewCnt_ff == SLEW_CYC - 8'h01);

  always_ff @(posedge clock) begin
    if (srst) begin
      qualCnt_ff <= 12'h000;
      slewCnt_ff <= 8'h00;
    end else if (ce) begin
      qualCnt_ff <= nxt_qualCnt;
      slewCnt_ff <= nxt_slewCnt;
    end
  end

  // Status flags that follow the qualified levels
  always_ff @(posedge clock) begin
    if (srst) begin
      powerOnGood_ff <= 1'b0;
      svidValid_ff <= 1'b0;
      adcEnable_ff <= 1'b0;
      droopSenseSrcEn_ff <= 1'b0;
      readyLineLevel_ff <= 2'b00;
    end else if (ce) begin
      powerOnGood_ff <= porS;
      svidValid_ff <= svidOpen;
      adcEnable_ff <= enS;
      droopSenseSrcEn_ff <= chipOn;
      readyLineLevel_ff <= sync2_ff.readyLine;
    end
  end

  // ========================================================================
  // Strap capture: graphics disable tracks before enable, the rest at qualification end
  vps_pkg::vps_strap_t nxt_strap;

  always_comb begin
    nxt_strap = strap_ff;
    if (!porS) begin
      nxt_strap = '0;
    end else if (!enS) begin
      nxt_strap.gfxDisable = sync2_ff.gfxSenseNegativeHigh;
    end else if (qualDone) begin
      nxt_strap.coreDroopEn = hystPick(sync2_ff.coreDroopStrapHigh, sync2_ff.coreDroopStrapLow,
        strap_ff.coreDroopEn);
      nxt_strap.gfxDroopEn = hystPick(sync2_ff.gfxDroopStrapHigh, sync2_ff.gfxDroopStrapLow,
        strap_ff.gfxDroopEn);
      nxt_strap.gfxForceDem = hystPick(sync2_ff.gfxLightLoadStrapHigh, sync2_ff.gfxLightLoadStrapLow,
        strap_ff.gfxForceDem);
      nxt_strap.coreBoot = sync2_ff.coreBootStrap;
      nxt_strap.gfxBoot = sync2_ff.gfxBootStrap;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      strap_ff <= '0;
      gfxDiodeEmulationMode_ff <= 1'b0;
    end else if (ce) begin
      strap_ff <= nxt_strap;
      gfxDiodeEmulationMode_ff <= strap_ff.gfxForceDem | hostPsDem;
    end
  end

  // ========================================================================
  // Protection latches: power-on-good low is the only clear, and it beats a new event
  vps_pkg::vps_faults_t faultEvt;
  assign faultEvt = {sync2_ff.overvoltageEvt, sync2_ff.overcurrentEvt,
    sync2_ff.undervoltageEvt, sync2_ff.overtempEvt};

  always_ff @(posedge clock) begin
    if (srst) begin
      faultLatch_ff <= '0;
    end else if (ce) begin
      faultLatch_ff <= porS ? (faultLatch_ff | faultEvt) : '0;
    end
  end

  // ========================================================================
  // Platform limits: ADC code is already amps or degrees, informational only
  always_ff @(posedge clock) begin
    if (srst) begin
      limits_ff <= {3{`VPS_LIMIT_RESET}};
    end else if (ce && adcDone && enS) begin
      limits_ff <= adcSample;
    end
  end

  // Host readback by data register index
  wire [7:0] rdIcc = regRdGfx ? limits_ff.gfxIccMax : limits_ff.coreIccMax;
  wire rdIsIcc = (regRdIndex == `VPS_REG_MAX_CURRENT_REG);
  wire rdIsTemp = (regRdIndex == `VPS_REG_TEMP_MAX) && !regRdGfx;
  wire [7:0] rdData = rdIsIcc ? rdIcc : (rdIsTemp ? limits_ff.coreTempMax : `VPS_REG_NONE);

  always_ff @(posedge clock) begin
    if (srst) begin
      regRdData_ff <= `VPS_REG_NONE;
    end else if (ce) begin
      regRdData_ff <= rdData;
    end
  end

  // ========================================================================
  // Rails; host commands are dropped until the bus is valid
  wire coreOn = chipOn;
  wire gfxOn = chipOn && !strap_ff.gfxDisable;
  wire coreVidStb = vidStb && svidValid_ff && !vidRailGfx;
  wire gfxVidStb = vidStb && svidValid_ff && vidRailGfx;
  wire [REF_W-1:0] coreBootSteps = bootSteps(sync2_ff.coreBootStrap);
  wire [REF_W-1:0] gfxBootSteps = bootSteps(sync2_ff.gfxBootStrap);
  vps_pkg::vps_rail_state_t coreState;
  vps_pkg::vps_rail_state_t gfxState;
  logic [REF_W-1:0] coreRefSteps;
  logic [REF_W-1:0] gfxRefSteps;
  logic coreReady;
  logic gfxReady;

  // Timer also waits out a rail still ramping down, else that rail would miss qualDone and stick
  wire railDraining = (coreState == vps_pkg::RS_RAMP_DOWN) || (gfxState == vps_pkg::RS_RAMP_DOWN);
  assign nxt_qualCnt = (!chipOn || railDraining) ? 12'h000 :
    (qualCnt_ff == QUAL_CYC) ? qualCnt_ff : qualCnt_ff + 12'h001;

  vps_rail_seq #(.REF_W(REF_W)) uCoreRail (
    .clock(clock),
    .srst(srst),
    .ce(ce),
    .railOn(coreOn),
    .qualDone(qualDone),
    .slewTick(slewTick),
    .bootSteps(coreBootSteps),
    .vidStb(coreVidStb),
    .vidTarget(vidTarget),
    .state_ff(coreState),
    .refSteps_ff(coreRefSteps),
    .ready_ff(coreReady)
  );

  vps_rail_seq #(.REF_W(REF_W)) uGfxRail (
    .clock(clock),
    .srst(srst),
    .ce(ce),
    .railOn(gfxOn),
    .qualDone(qualDone),
    .slewTick(slewTick),
    .bootSteps(gfxBootSteps),
    .vidStb(gfxVidStb),
    .vidTarget(vidTarget),
    .state_ff(gfxState),
    .refSteps_ff(gfxRefSteps),
    .ready_ff(gfxReady)
  );

  // Outputs retimed; ready is gated by power-on-good so it drops without waiting for the ramp
  wire anyRailBusy = (coreState != vps_pkg::RS_OFF) || (gfxState != vps_pkg::RS_OFF);

  always_ff @(posedge clock) begin
    if (srst) begin
      coreRef_ff <= '0;
      gfxRef_ff <= '0;
      coreReadyOut_ff <= 1'b0;
      gfxReadyOut_ff <= 1'b0;
      coreReadyOeN_ff <= 1'b0;
      gfxReadyOeN_ff <= 1'b0;
      railsActive_ff <= 1'b0;
    end else if (ce) begin
      coreRef_ff <= coreRefSteps;
      gfxRef_ff <= gfxRefSteps;
      coreReadyOut_ff <= 1'b0;
      gfxReadyOut_ff <= 1'b0;
      coreReadyOeN_ff <= coreReady && porS;
      gfxReadyOeN_ff <= gfxReady && porS;
      railsActive_ff <= chipOn || anyRailBusy;
    end
  end

  // ========================================================================
  // Checks
  default clocking @(posedge clock); endclocking
  default disable iff (srst);

  sequence s_core_leaves_qual;
    ($past(coreState) == vps_pkg::RS_QUAL) ##0
      (coreState == vps_pkg::RS_RAMP_BOOT || coreState == vps_pkg::RS_HOLD);
  endsequence

  sequence s_ready_dropped;
    !coreReadyOeN_ff && !gfxReadyOeN_ff;
  endsequence

  a_por_follow: assert property ((ce && porS) |=> powerOnGood_ff)
    else $error("power-on-good flag did not follow the supply");
  a_qual_wait: assert property (s_core_leaves_qual |-> ($past(qualCnt_ff) == QUAL_CYC - 12'h001))
    else $error("rail left qualification early or late");
  a_latch_clear: assert property ((ce && !porS) |=> (faultLatch_ff == '0))
    else $error("protection latches not cleared on power-on-good low");
  a_latch_keep: assert property ((ce && porS && faultLatch_ff.overvoltageLatch) |=> faultLatch_ff.overvoltageLatch)
    else $error("overvoltage latch cleared without power-on-good low");
  a_serial_voltage_id_bus_window: assert property (svidValid_ff |-> ($past(qualCnt_ff) >= SERIAL_VOLTAGE_ID_BUS_CYC))
    else $error("bus marked valid before the invalid window ended");
  a_serial_voltage_id_bus_drop: assert property ((ce && !chipOn) |=> !svidValid_ff)
    else $error("bus still valid while disabled");
  a_ready_drop: assert property ((ce && !porS) |=> s_ready_dropped)
    else $error("ready not pulled low after power-on-good fell");
  a_adc_gate: assert property (!enS |=> $stable(limits_ff))
    else $error("limits changed while enable low");
  a_adc_take: assert property ((ce && adcDone && enS) |=> (limits_ff == $past(adcSample)))
    else $error("sampled limit not stored");
  a_limit_range: assert property (limits_ff.coreTempMax <= ADC_LEVELS)
    else $error("limit above ADC range");
  a_strap_hold: assert property ((porS && enS && !qualDone) |=> $stable(strap_ff))
    else $error("strap decision changed after capture");
  a_droop_dead_band: assert property ((ce && qualDone && !sync2_ff.coreDroopStrapHigh && !sync2_ff.coreDroopStrapLow)
    |=> $stable(strap_ff.coreDroopEn))
    else $error("droop setting toggled in the dead band");
  a_dem_force: assert property ((ce && strap_ff.gfxForceDem) |=> gfxDiodeEmulationMode_ff)
    else $error("forced diode emulation not applied");
  a_droop_source: assert property ((ce && chipOn) |=> droopSenseSrcEn_ff)
    else $error("droop sense current not sourced after enable");

endmodule

`default_nettype wire

// ---- design/vps_power_seq_cfg.svh ----
// Timing counts, field settings, reset values and register indices for the power sequencer
`ifndef VPS_POWER_SEQ_CFG_SVH
`define VPS_POWER_SEQ_CFG_SVH

// ==========================================================================
// Clock and timing
`define VPS_CLK_MHZ 10
`define VPS_QUAL_US 300
`define VPS_SERIAL_VOLTAGE_ID_BUS_INVALID_US 300
`define VPS_SLEW_UV_PER_US 3125

// ==========================================================================
// Reference scale: one step of the reference counter
`define VPS_REF_STEP_UV 3125
`define VPS_UV_PER_MV 1000
`define VPS_BOOT_1V1_MV 1100
`define VPS_BOOT_1V0_MV 1000
`define VPS_BOOT_0V9_MV 900
`define VPS_SHUTDOWN_MV 200

// ==========================================================================
// Limit ADC and readback
`define VPS_ADC_LEVELS 255
`define VPS_REG_MAX_CURRENT_REG 8'h21
`define VPS_REG_TEMP_MAX 8'h22
`define VPS_REG_NONE 8'h00
`define VPS_LIMIT_RESET 8'h00

`endif

// ---- design/vps_pkg.sv ----
// Types shared by the power sequencer and its rail state machine
`default_nettype none

package vps_pkg;

  // ========================================================================
  // Boot-voltage strap decision, from the comparator ladder
  typedef enum logic [1:0] {
    VPS_BOOT_0V0 = 2'b00,
    VPS_BOOT_0V9 = 2'b01,
    VPS_BOOT_1V0 = 2'b10,
    VPS_BOOT_1V1 = 2'b11
  } vps_boot_t;

  // ========================================================================
  // Per-rail sequencing states
  typedef enum logic [2:0] {
    RS_OFF       = 3'b000,
    RS_QUAL      = 3'b001,
    RS_RAMP_BOOT = 3'b010,
    RS_HOLD      = 3'b011,
    RS_RAMP_TGT  = 3'b100,
    RS_REGULATE  = 3'b101,
    RS_RAMP_DOWN = 3'b110
  } vps_rail_state_t;

  // ========================================================================
  // Asynchronous comparator levels arriving from the analog side
  typedef struct packed {
    logic supplyAboveUvlo;
    logic enableAboveThreshold;
    logic gfxSenseNegativeHigh;
    logic gfxLightLoadStrapHigh;
    logic gfxLightLoadStrapLow;
    logic coreDroopStrapHigh;
    logic coreDroopStrapLow;
    logic gfxDroopStrapHigh;
    logic gfxDroopStrapLow;
    vps_boot_t coreBootStrap;
    vps_boot_t gfxBootStrap;
    logic overvoltageEvt;
    logic overcurrentEvt;
    logic undervoltageEvt;
    logic overtempEvt;
    logic [1:0] readyLine;
  } vps_pins_t;

  typedef struct packed {
    logic overvoltageLatch;
    logic overcurrentLatch;
    logic undervoltageLatch;
    logic overtempLatch;
  } vps_faults_t;

  typedef struct packed {
    logic gfxDisable;
    logic gfxForceDem;
    logic coreDroopEn;
    logic gfxDroopEn;
    vps_boot_t coreBoot;
    vps_boot_t gfxBoot;
  } vps_strap_t;

  typedef struct packed {
    logic [7:0] coreIccMax;
    logic [7:0] gfxIccMax;
    logic [7:0] coreTempMax;
  } vps_limits_t;

endpackage

`default_nettype wire

// ---- design/vps_rail_seq.sv ----
// Start-up, regulation and soft shutdown state machine for one rail
`timescale 1ns/1ps
`default_nettype none
`include "vps_power_seq_cfg.svh"

module vps_rail_seq #(
  parameter int REF_W = 10
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic ce,
  input wire logic railOn,
  input wire logic qualDone,
  input wire logic slewTick,
  input wire logic [REF_W-1:0] bootSteps,
  input wire logic vidStb,
  input wire logic [REF_W-1:0] vidTarget,
  output vps_pkg::vps_rail_state_t state_ff,
  output logic [REF_W-1:0] refSteps_ff,
  output logic ready_ff
);

  localparam logic [REF_W-1:0] FLOOR =
    REF_W'(`VPS_SHUTDOWN_MV * `VPS_UV_PER_MV / `VPS_REF_STEP_UV);

  vps_pkg::vps_rail_state_t nxt_state;
  logic [REF_W-1:0] tgt_ff;
  logic [REF_W-1:0] nxt_tgt;
  logic [REF_W-1:0] nxt_refSteps;
  logic nxt_ready;
  wire atTarget = (refSteps_ff == tgt_ff);

  // One reference step toward the target
  function automatic logic [REF_W-1:0] stepToward(input logic [REF_W-1:0] r, input logic [REF_W-1:0] t);
    if (r < t) stepToward = r + 1'b1;
    else if (r > t) stepToward = r - 1'b1;
    else stepToward = r;
  endfunction

  // ========================================================================
  // Next-state logic; losing the rail enable always wins over host commands
  always_comb begin
    nxt_state = state_ff;
    nxt_refSteps = refSteps_ff;
    nxt_tgt = tgt_ff;
    nxt_ready = ready_ff;
    if (!railOn && state_ff != vps_pkg::RS_OFF && state_ff != vps_pkg::RS_RAMP_DOWN) begin
      nxt_state = vps_pkg::RS_RAMP_DOWN;
      nxt_ready = 1'b0;
    end else begin
      unique case (state_ff)
        vps_pkg::RS_OFF: begin
          if (railOn) nxt_state = vps_pkg::RS_QUAL;
        end
        vps_pkg::RS_QUAL: begin
          if (qualDone) begin
            nxt_tgt = bootSteps;
            nxt_state = (bootSteps == '0) ? vps_pkg::RS_HOLD : vps_pkg::RS_RAMP_BOOT;
          end
        end
        vps_pkg::RS_RAMP_BOOT: begin
          if (atTarget) nxt_state = vps_pkg::RS_HOLD;
          else if (slewTick) nxt_refSteps = stepToward(refSteps_ff, tgt_ff);
        end
        vps_pkg::RS_HOLD: begin
          if (vidStb) begin
            nxt_tgt = vidTarget;
            nxt_state = vps_pkg::RS_RAMP_TGT;
          end
        end
        vps_pkg::RS_RAMP_TGT: begin
          if (vidStb) nxt_tgt = vidTarget;
          else if (atTarget) begin
            nxt_state = vps_pkg::RS_REGULATE;
            nxt_ready = 1'b1;
          end else if (slewTick) nxt_refSteps = stepToward(refSteps_ff, tgt_ff);
        end
        vps_pkg::RS_REGULATE: begin
          // Ready stays up across later voltage changes
          if (vidStb) nxt_tgt = vidTarget;
          else if (!atTarget && slewTick) nxt_refSteps = stepToward(refSteps_ff, tgt_ff);
        end
        vps_pkg::RS_RAMP_DOWN: begin
          nxt_tgt = '0;
          nxt_ready = 1'b0;
          if (refSteps_ff < FLOOR) begin
            nxt_state = vps_pkg::RS_OFF;
            nxt_refSteps = '0;
          end else if (slewTick) nxt_refSteps = refSteps_ff - 1'b1;
        end
        default: begin
          nxt_state = vps_pkg::RS_OFF;
          nxt_refSteps = '0;
          nxt_ready = 1'b0;
        end
      endcase
    end
  end

  // State registers, frozen while the clock enable is low
  always_ff @(posedge clock) begin
    if (srst) begin
      state_ff <= vps_pkg::RS_OFF;
      refSteps_ff <= '0;
      tgt_ff <= '0;
      ready_ff <= 1'b0;
    end else if (ce) begin
      state_ff <= nxt_state;
      refSteps_ff <= nxt_refSteps;
      tgt_ff <= nxt_tgt;
      ready_ff <= nxt_ready;
    end
  end

  // ========================================================================
  // Checks
  default clocking @(posedge clock); endclocking
  default disable iff (srst);

  a_zero_boot_hold: assert property ((ce && railOn && state_ff == vps_pkg::RS_QUAL && qualDone && bootSteps == '0)
    |=> (state_ff == vps_pkg::RS_HOLD && refSteps_ff == '0))
    else $error("zero boot strap did not hold the reference at zero");
  a_ready_at_target: assert property ($rose(ready_ff) |-> (refSteps_ff == tgt_ff))
    else $error("ready rose before the target was reached");
  a_down_slew_rate: assert property ((ce && state_ff == vps_pkg::RS_RAMP_DOWN && !slewTick && refSteps_ff >= FLOOR)
    |=> $stable(refSteps_ff))
    else $error("ramp-down moved between slew ticks");
  a_down_floor_off: assert property ((ce && state_ff == vps_pkg::RS_RAMP_DOWN && refSteps_ff < FLOOR)
    |=> (state_ff == vps_pkg::RS_OFF && refSteps_ff == '0))
    else $error("shutdown did not complete below the floor");

endmodule

`default_nettype wire

// ---- test/vps_strap_model.sv ----
// Platform strap, fault source and ready pull-up model for the power sequencer
`timescale 1ns/1ps
`default_nettype none
module vps_strap_model (
  input wire logic supplyOn,
  input wire logic enableOn,
  input wire logic ovEvt,
  input wire logic coreOeN,
  input wire logic gfxOeN,
  output vps_pkg::vps_pins_t pins
);
  // Straps sit firmly on one side, except the core droop strap, parked in the dead band
  always_comb begin
    pins = '0;
    pins.supplyAboveUvlo = supplyOn;
    pins.enableAboveThreshold = enableOn;
    pins.gfxLightLoadStrapHigh = 1'b1;
    pins.gfxDroopStrapHigh = 1'b1;
    pins.coreDroopStrapLow = 1'b0; // Neither comparator set: keep the disabled default
    pins.coreBootStrap = vps_pkg::VPS_BOOT_1V1;
    pins.gfxBootStrap = vps_pkg::VPS_BOOT_0V0;
    pins.overvoltageEvt = ovEvt;
    pins.readyLine = {gfxOeN, coreOeN}; // Board pull-up wins when released
  end
endmodule
`default_nettype wire

// ---- test/test_vps_power_seq.sv ----
// Self-checking bench for the power sequencer top
`timescale 1ns/1ps
`default_nettype none
module test_vps_power_seq;
  logic clock = 0, srst = 1, supplyOn = 0, enableOn = 0, ovEvt = 0, adcDone = 0, vidStb = 0, regRdGfx = 0;
  logic vidRailGfx = 0, hostPsDem = 0;
  logic [23:0] adcSample = '0;
  logic [9:0] vidTarget = '0;
  logic [7:0] regRdIndex = '0;
  logic [31:0] rnd = 32'h16e8bba1;
  int err_total = 0, checked = 0;
  logic [31:0] expQ[$];
  int selQ[$];
  event look;
  vps_pkg::vps_pins_t pins;
  vps_pkg::vps_strap_t strap;
  vps_pkg::vps_faults_t flt;
  vps_pkg::vps_limits_t lim;
  logic pog, serial_voltage_id_bus, adcEn, drpSrc, diode_emulation_mode, cOut, cOe, gOut, gOe, act;
  logic [1:0] lvl;
  logic [9:0] cRef, gRef;
  logic [7:0] rd;
  logic [31:0] pr [16];
  // ==========================================
  // Clock, design and far side
  initial forever #50 clock = ~clock;
  vps_power_seq u_dut (.clock(clock), .srst(srst), .ce(1'b1), .pinsAsync(pins), .adcSample(adcSample),
    .adcDone(adcDone), .vidStb(vidStb), .vidRailGfx(vidRailGfx), .vidTarget(vidTarget), .hostPsDem(hostPsDem),
    .regRdIndex(regRdIndex), .regRdGfx(regRdGfx), .powerOnGood_ff(pog), .svidValid_ff(serial_voltage_id_bus),
    .adcEnable_ff(adcEn), .droopSenseSrcEn_ff(drpSrc), .strap_ff(strap), .faultLatch_ff(flt),
    .limits_ff(lim), .gfxDiodeEmulationMode_ff(diode_emulation_mode), .coreRef_ff(cRef), .gfxRef_ff(gRef),
    .coreReadyOut_ff(cOut), .coreReadyOeN_ff(cOe), .gfxReadyOut_ff(gOut), .gfxReadyOeN_ff(gOe),
    .readyLineLevel_ff(lvl), .regRdData_ff(rd), .railsActive_ff(act));
  vps_strap_model u_far (.supplyOn(supplyOn), .enableOn(enableOn), .ovEvt(ovEvt), .coreOeN(cOe),
    .gfxOeN(gOe), .pins(pins));
  // Probe table, indexed by the notes
  always_comb pr = '{32'(pog), 32'(serial_voltage_id_bus), 32'(cRef), 32'(cOe), 32'(flt), 32'(lim), 32'(rd), 32'(strap),
    32'(diode_emulation_mode), 32'(act), 32'(gRef), 32'(drpSrc), 32'(adcEn), 32'({gOut, cOut}), 32'(gOe), 32'(lvl)};
  // ==========================================
  // Helpers
  function automatic logic [31:0] lfsr(logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  task automatic step(int n);
    repeat (n) @(negedge clock);
  endtask
  task automatic note(int s, logic [31:0] v);
    selQ.push_back(s);
    expQ.push_back(v);
    ->look;
  endtask
  task automatic chk(logic [31:0] seen, logic [31:0] want);
    checked++;
    if (seen !== want) begin
      err_total++;
      $display("unexpected at %0t: seen %0h want %0h", $time, seen, want);
    end
  endtask
  task automatic wrap_up();
    $display("checked %0d err_total %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // Bounded wait; running out counts as a mismatch and ends the run
  task automatic waitFor(int s, logic [31:0] v, int n);
    while (pr[s] !== v && n > 0) begin
      step(1);
      n--;
    end
    if (pr[s] !== v) begin
      err_total++;
      wrap_up();
    end
  endtask
  task automatic pulseAdc();
    rnd = lfsr(rnd);
    adcSample = rnd[23:0];
    adcDone = 1;
    step(1);
    adcDone = 0;
  endtask
  // Monitor drains the notes once the outputs have settled
  initial forever begin
    @(look);
    #1;
    while (selQ.size() > 0) chk(pr[selQ.pop_front()], expQ.pop_front());
  end
  // ==========================================
  // Main sequence
  initial begin
    step(4);
    srst = 0;
    note(1, 0);
    note(3, 0);
    supplyOn = 1;
    step(4);
    note(0, 1);
    note(2, 0);
    ovEvt = 1;
    step(2);
    ovEvt = 0;
    pulseAdc();
    step(4);
    note(4, 32'h8);
    note(5, 0);
    enableOn = 1;
    step(5);
    note(11, 1);
    note(12, 1);
    enableOn = 0;
    step(5);
    note(4, 32'h8);
    note(12, 0);
    enableOn = 1;
    step(2990);
    note(1, 0);
    note(2, 0);
    waitFor(1, 1, 30);
    note(7, 32'h5c);
    note(8, 1);
    waitFor(2, 32'd352, 3700);
    step(50);
    note(2, 32'd352);
    note(10, 0);
    note(3, 0);
    pulseAdc();
    regRdIndex = 8'h21;
    step(2);
    note(5, rnd[23:0]);
    note(6, rnd[23:16]);
    regRdGfx = 1;
    step(2);
    note(6, rnd[15:8]);
    regRdIndex = 8'h22;
    regRdGfx = 0;
    step(2);
    note(6, rnd[7:0]);
    regRdIndex = 8'h30;
    step(2);
    note(6, 0);
    vidTarget = 10'd372;
    vidStb = 1;
    step(1);
    // Strobe stays up; the second command goes to the graphics rail
    vidRailGfx = 1;
    vidTarget = 10'd8;
    step(1);
    vidStb = 0;
    vidRailGfx = 0;
    waitFor(3, 1, 260);
    note(2, 32'd372);
    note(10, 32'd8);
    note(14, 1);
    note(13, 0);
    step(4);
    note(15, 32'h3);
    supplyOn = 0;
    step(4);
    note(3, 0);
    note(14, 0);
    note(4, 0);
    note(7, 0);
    note(8, 0);
    hostPsDem = 1;
    step(2);
    note(8, 1);
    waitFor(2, 32'd300, 760);
    waitFor(9, 0, 2500);
    note(2, 0);
    step(2);
    wrap_up();
  end
endmodule
`default_nettype wire
